// ---- dmad_pkg.sv ----
// Purpose: shared constants and carriers for the data memory address decoder
// Assumes: 8-bit core, one system clock
// Notes:   all offsets and reset values live here
package dmad_pkg;
  localparam logic [15:0] DMAD_FLASH_BASE      = 16'h0000;
  localparam logic [15:0] DMAD_FLASH_END_LARGE = 16'h3BFF;
  localparam logic [15:0] DMAD_FLASH_END_SMALL = 16'h1FFF;
  localparam logic [7:0]  DMAD_SP_RESET        = 8'h07;
  localparam logic [7:0]  DMAD_LOWER_LIMIT     = 8'h7F;
  localparam logic [7:0]  DMAD_BANK_TOP        = 8'h1F;
  localparam logic [7:0]  DMAD_BIT_BASE        = 8'h20;
  localparam logic [7:0]  DMAD_BIT_TOP         = 8'h2F;
  localparam logic [7:0]  DMAD_SFR_SP          = 8'h81;
  localparam logic [7:0]  DMAD_SFR_DPL         = 8'h82;
  localparam logic [7:0]  DMAD_SFR_DPH         = 8'h83;
  localparam logic [7:0]  DMAD_SFR_PAGE        = 8'hAA;
  localparam logic [7:0]  DMAD_SFR_STATUS      = 8'hD0;
  localparam int          DMAD_RS_LO_POS       = 3;
  localparam int          DMAD_RS_HI_POS       = 4;
  localparam int          DMAD_PAGE_SELECT_BIT_POS       = 0;
  localparam int          DMAD_IRAM_DEPTH      = 256;
  localparam int          DMAD_ON_CHIP_EXTERNAL_RAM_DEPTH      = 512;

  typedef enum logic [2:0]
  {
    DMAD_OP_NONE      = 3'h0,
    DMAD_OP_DIRECT    = 3'h1,
    DMAD_OP_INDIRECT  = 3'h2,
    DMAD_OP_BIT       = 3'h3,
    DMAD_OP_PUSH      = 3'h4,
    DMAD_OP_POP       = 3'h5,
    DMAD_OP_XDPTR     = 3'h6,
    DMAD_OP_XRI       = 3'h7
  } dmad_op_t;

  typedef struct packed
  {
    dmad_op_t   op;
    logic       wr;
    logic [7:0] addr;
    logic       ri_sel;
    logic [7:0] wdata;
    logic       bit_val;
    logic       code_rd;
    logic [15:0] code_addr;
  } dmad_req_t;

  typedef struct packed
  {
    logic       valid;
    logic [7:0] rdata;
    logic       bit_val;
    logic       sfr_hit;
    logic       flash_sel;
    logic       flash_wr;
    logic [15:0] addr;
    logic       reserved;
    logic       lock_byte;
  } dmad_rsp_t;
endpackage

// ---- dmad_core.sv ----
// Purpose: memory steering: internal RAM, banks, bits, stack, on_chip_external_ram, code space
// Assumes: requests are single cycle; answers are one cycle later
// Notes:   storage is flip-flops; unknown sfr addresses read as zero
`timescale 1ns/1ps
module dmad_core
(
  input  wire logic              clock,         // system clock, 10 MHz
  input  wire logic              rst,           // synchronous reset, high
  input  wire logic              large_variant, // 1: larger flash size
  input  wire logic              flash_target,  // 1: external writes go to flash
  input  wire dmad_pkg::dmad_req_t req,         // request from execution unit
  output      dmad_pkg::dmad_rsp_t rsp          // answer, one cycle later
);
  import dmad_pkg::*;

  // ------------------------------------------------------------
  // state
  // ------------------------------------------------------------
  typedef struct packed
  {
    logic [DMAD_IRAM_DEPTH-1:0][7:0] iram;
    logic [DMAD_ON_CHIP_EXTERNAL_RAM_DEPTH-1:0][7:0] on_chip_external_ram;
    logic [7:0]  sp;
    logic [15:0] data_pointer_16bit;
    logic        page_select_bit;
    logic [7:0]  status;
    dmad_rsp_t   rsp;
  } dmad_state_t;

  dmad_state_t st_r;
  dmad_state_t st_nxt;

  assign rsp = st_r.rsp;

  // ------------------------------------------------------------
  // decode
  // ------------------------------------------------------------
  logic [1:0]  bank;
  logic [7:0]  ri_addr;
  logic [7:0]  ind_addr;
  logic [7:0]  bit_byte;
  logic [2:0]  bit_pos;
  logic [8:0]  x_addr;
  logic [15:0] x_full;
  logic [15:0] flash_end;
  logic [7:0]  sfr_rd;

  always_comb
  begin
    bank      = {st_r.status[DMAD_RS_HI_POS], st_r.status[DMAD_RS_LO_POS]};
    ri_addr   = {3'h0, bank, 2'h0, req.ri_sel};
    ind_addr  = st_r.iram[ri_addr];
    bit_byte  = DMAD_BIT_BASE + {4'h0, req.addr[6:3]};
    bit_pos   = req.addr[2:0];
    if (req.op == DMAD_OP_XDPTR)
    begin
      x_full = st_r.data_pointer_16bit;
    end
    else
    begin
      x_full = {7'h00, st_r.page_select_bit, ind_addr};
    end
    x_addr    = x_full[8:0];
    flash_end = large_variant ? DMAD_FLASH_END_LARGE : DMAD_FLASH_END_SMALL;
    unique case (req.addr)
      DMAD_SFR_SP:     sfr_rd = st_r.sp;
      DMAD_SFR_DPL:    sfr_rd = st_r.data_pointer_16bit[7:0];
      DMAD_SFR_DPH:    sfr_rd = st_r.data_pointer_16bit[15:8];
      DMAD_SFR_PAGE:   sfr_rd = {7'h00, st_r.page_select_bit};
      DMAD_SFR_STATUS: sfr_rd = st_r.status;
      default:         sfr_rd = 8'h00;
    endcase
  end

  // ------------------------------------------------------------
  // next state
  // ------------------------------------------------------------
  always_comb
  begin
    st_nxt = st_r;
    st_nxt.rsp = '0;
    st_nxt.rsp.valid = (req.op != DMAD_OP_NONE) || req.code_rd;
    if (req.code_rd)
    begin
      // code reads always resolve to flash; data comes from the flash array outside
      st_nxt.rsp.flash_sel = 1'b1;
      st_nxt.rsp.addr      = req.code_addr;
      st_nxt.rsp.lock_byte = (req.code_addr == flash_end);
      st_nxt.rsp.reserved  = (req.code_addr > flash_end);
    end
    unique case (req.op)
      DMAD_OP_NONE:
      begin
      end
      DMAD_OP_DIRECT:
      begin
        st_nxt.rsp.addr = {8'h00, req.addr};
        if (req.addr > DMAD_LOWER_LIMIT)
        begin
          st_nxt.rsp.sfr_hit = 1'b1;
          st_nxt.rsp.rdata   = sfr_rd;
          if (req.wr)
          begin
            unique case (req.addr)
              DMAD_SFR_SP:     st_nxt.sp          = req.wdata;
              DMAD_SFR_DPL:    st_nxt.data_pointer_16bit[7:0]   = req.wdata;
              DMAD_SFR_DPH:    st_nxt.data_pointer_16bit[15:8]  = req.wdata;
              DMAD_SFR_PAGE:   st_nxt.page_select_bit       = req.wdata[DMAD_PAGE_SELECT_BIT_POS];
              DMAD_SFR_STATUS: st_nxt.status      = req.wdata;
              default:
              begin
              end
            endcase
          end
        end
        else
        begin
          st_nxt.rsp.rdata = st_r.iram[req.addr];
          if (req.wr)
          begin
            st_nxt.iram[req.addr] = req.wdata;
          end
        end
      end
      DMAD_OP_INDIRECT:
      begin
        // whole 256 bytes: upper half is ram, never sfrs
        st_nxt.rsp.addr  = {8'h00, ind_addr};
        st_nxt.rsp.rdata = st_r.iram[ind_addr];
        if (req.wr)
        begin
          st_nxt.iram[ind_addr] = req.wdata;
        end
      end
      DMAD_OP_BIT:
      begin
        // op code alone marks a bit access; addr is a bit address here
        st_nxt.rsp.addr    = {8'h00, bit_byte};
        st_nxt.rsp.bit_val = st_r.iram[bit_byte][bit_pos];
        st_nxt.rsp.rdata   = st_r.iram[bit_byte];
        if (req.wr)
        begin
          st_nxt.iram[bit_byte][bit_pos] = req.bit_val;
        end
      end
      DMAD_OP_PUSH:
      begin
        // 8-bit wrap lets the stack span all 256 bytes
        st_nxt.sp = st_r.sp + 8'h01;
        st_nxt.iram[st_nxt.sp] = req.wdata;
        st_nxt.rsp.addr = {8'h00, st_nxt.sp};
      end
      DMAD_OP_POP:
      begin
        st_nxt.rsp.rdata = st_r.iram[st_r.sp];
        st_nxt.rsp.addr  = {8'h00, st_r.sp};
        st_nxt.sp        = st_r.sp - 8'h01;
      end
      DMAD_OP_XDPTR, DMAD_OP_XRI:
      begin
        st_nxt.rsp.addr = x_full;
        if (req.wr && flash_target)
        begin
          // write leaves as a flash write request; on_chip_external_ram untouched
          st_nxt.rsp.flash_sel = 1'b1;
          st_nxt.rsp.flash_wr  = 1'b1;
        end
        else
        begin
          st_nxt.rsp.rdata = st_r.on_chip_external_ram[x_addr];
          if (req.wr)
          begin
            st_nxt.on_chip_external_ram[x_addr] = req.wdata;
          end
        end
      end
      default:
      begin
      end
    endcase
  end

  // ------------------------------------------------------------
  // registers
  // ------------------------------------------------------------
  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      st_r        <= '0;
      st_r.sp     <= DMAD_SP_RESET;
    end
    else
    begin
      st_r <= st_nxt;
    end
  end
endmodule

// ---- dmad_monitor.sv ----
// Purpose: port-level checks of the data memory address decoder
// Assumes: one clock, synchronous active-high reset
// Notes:   bound into every dmad_core instance
`timescale 1ns/1ps
module dmad_monitor
(
  input wire logic                clock,         // system clock
  input wire logic                rst,           // synchronous reset
  input wire logic                large_variant, // flash size select
  input wire logic                flash_target,  // external writes to flash
  input wire dmad_pkg::dmad_req_t req,           // request
  input wire dmad_pkg::dmad_rsp_t rsp            // answer
);
  import dmad_pkg::*;
  // ----
  // checks
  // ----
  default clocking @(posedge clock); endclocking
  default disable iff (rst);
  logic [15:0] fend;
  logic        take;
  assign fend = large_variant ? DMAD_FLASH_END_LARGE : DMAD_FLASH_END_SMALL;
  assign take = (req.op != DMAD_OP_NONE) || req.code_rd;
  sequence s_push2;
    req.op == DMAD_OP_PUSH ##1 req.op == DMAD_OP_PUSH;
  endsequence
  sequence s_push_pop;
    req.op == DMAD_OP_PUSH ##1 req.op == DMAD_OP_POP;
  endsequence
  AST_ANSWER: assert property (take |=> rsp.valid)
    else $error("request got no answer");
  AST_IDLE: assert property (!take |=> !rsp.valid)
    else $error("answer without request");
  AST_PUSH_UP: assert property (s_push2 |=> rsp.addr == $past(rsp.addr) + 16'h0001)
    else $error("second push not one above first");
  AST_POP_SAME: assert property (s_push_pop |=> rsp.addr == $past(rsp.addr))
    else $error("pop not at last pushed place");
  AST_ON_CHIP_EXTERNAL_RAM: assert property ((req.op inside {DMAD_OP_XDPTR, DMAD_OP_XRI}) && !flash_target
    |=> !rsp.flash_sel)
    else $error("external move left the ram");
  AST_FLASH_WR: assert property ((req.op inside {DMAD_OP_XDPTR, DMAD_OP_XRI}) && req.wr
    && flash_target |=> rsp.flash_sel && rsp.flash_wr)
    else $error("redirected write missed flash");
  AST_LOCK: assert property (req.code_rd && req.code_addr == fend
    |=> rsp.lock_byte && !rsp.reserved)
    else $error("last flash byte not lock");
  AST_RSVD: assert property (req.code_rd && req.code_addr > fend |=> rsp.reserved)
    else $error("address above lock not reserved");
  AST_CODE: assert property (req.code_rd && req.code_addr < fend
    |=> rsp.flash_sel && !rsp.reserved)
    else $error("code read not from flash");
  AST_SFR_IND: assert property (req.op == DMAD_OP_INDIRECT |=> !rsp.sfr_hit)
    else $error("indirect access hit sfr");
  AST_SFR_DIR: assert property (req.op == DMAD_OP_DIRECT && req.addr[7] |=> rsp.sfr_hit)
    else $error("direct upper access missed sfr");
endmodule
bind dmad_core dmad_monitor i_mon (.clock(clock), .rst(rst), .large_variant(large_variant),
  .flash_target(flash_target), .req(req), .rsp(rsp));

// ---- dmad_exec_model.sv ----
// Purpose: execution unit stand-in issuing back-to-back requests
// Assumes: requests one cycle long, answer one cycle later
// Notes:   line returns to idle after each burst
`timescale 1ns/1ps
module dmad_exec_model
(
  input  wire logic                clock, // system clock
  input  wire dmad_pkg::dmad_rsp_t rsp,   // answer from decoder
  output dmad_pkg::dmad_req_t      req    // request to decoder
);
  import dmad_pkg::*;
  // ----
  // burst driver
  // ----
  initial req = '0;
  // answers are read at the edge, before that edge's update lands
  task automatic run(input dmad_req_t q[$], output dmad_rsp_t a[$]);
    a = {};
    for (int k = 0; k < q.size() + 2; k++)
    begin
      @(posedge clock);
      if (k >= 2)
        a.push_back(rsp);
      req <= (k < q.size()) ? q[k] : '0;
    end
  endtask
endmodule

// ---- dmad_core_tb.sv ----
// Purpose: directed tests of stack, banks, bits, sfr split, on_chip_external_ram, code space
// Assumes: model drives req; bench drives reset and configuration
// Notes:   answers checked by position in each burst
`timescale 1ns/1ps
module dmad_core_tb;
  import dmad_pkg::*;
  logic      clock = 0, rst = 1, large_variant = 0, flash_target = 0;
  dmad_req_t req;
  dmad_rsp_t rsp;
  dmad_req_t q[$];
  dmad_rsp_t a[$];
  dmad_req_t r;
  int        fail_count = 0, cmp_count = 0, cyc = 0;
  `define CHK(n, e, g) begin cmp_count++; if ((g) !== (e)) begin fail_count++; \
    $display("CHECK FAILED %s exp %0h got %0h", n, e, g); end end
  dmad_core i_dut (.clock(clock), .rst(rst), .large_variant(large_variant),
    .flash_target(flash_target), .req(req), .rsp(rsp));
  dmad_exec_model i_exec (.clock(clock), .rsp(rsp), .req(req));
  // ----
  // helpers
  // ----
  function automatic dmad_req_t mk(dmad_op_t o, logic w, logic [7:0] ad, logic [7:0] d,
    logic s = 0);
    mk = '{op: o, wr: w, addr: ad, ri_sel: s, wdata: d, bit_val: d[0], default: '0};
  endfunction
  task automatic go();
    i_exec.run(q, a);
    q = {};
  endtask
  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  initial forever #50 clock = ~clock;
  // bursts are short; far fewer cycles than this
  always @(posedge clock)
  begin
    cyc++;
    if (cyc == 600)
    begin
      fail_count++;
      complete_run();
    end
  end
  // ----
  // tests
  // ----
  initial
  begin
    repeat (6) @(posedge clock);
    rst <= 0;
    q = '{mk(DMAD_OP_PUSH, 1, 0, 8'hA5), mk(DMAD_OP_PUSH, 1, 0, 8'h5A), mk(DMAD_OP_POP, 0, 0, 0),
      mk(DMAD_OP_POP, 0, 0, 0), mk(DMAD_OP_DIRECT, 0, 8'h81, 0), mk(DMAD_OP_DIRECT, 0, 8'h08, 0),
      mk(DMAD_OP_DIRECT, 1, 8'h00, 8'h81), mk(DMAD_OP_INDIRECT, 1, 0, 8'h3C),
      mk(DMAD_OP_DIRECT, 0, 8'h81, 0), mk(DMAD_OP_INDIRECT, 0, 0, 0)};
    for (int b = 0; b < 4; b++)
    begin
      q.push_back(mk(DMAD_OP_DIRECT, 1, 8'hD0, 8'(b * 8)));
      q.push_back(mk(DMAD_OP_DIRECT, 1, 8'(b * 8 + 1), 8'(8'h40 + b)));
      q.push_back(mk(DMAD_OP_DIRECT, 1, 8'(8'h40 + b), 8'(8'h10 + b)));
      q.push_back(mk(DMAD_OP_INDIRECT, 0, 0, 0, 1));
    end
    q = {q, mk(DMAD_OP_DIRECT, 1, 8'hD0, 0), mk(DMAD_OP_DIRECT, 1, 8'h22, 8'h08),
      mk(DMAD_OP_BIT, 0, 8'h13, 0), mk(DMAD_OP_BIT, 0, 8'h12, 0), mk(DMAD_OP_BIT, 1, 8'h7F, 1),
      mk(DMAD_OP_DIRECT, 0, 8'h2F, 0), mk(DMAD_OP_DIRECT, 1, 8'h83, 8'h01),
      mk(DMAD_OP_DIRECT, 1, 8'h82, 8'hFF), mk(DMAD_OP_XDPTR, 1, 0, 8'hC3),
      mk(DMAD_OP_DIRECT, 1, 8'hAA, 8'hFF), mk(DMAD_OP_DIRECT, 0, 8'hAA, 0),
      mk(DMAD_OP_DIRECT, 1, 8'h00, 8'hFF), mk(DMAD_OP_XRI, 0, 0, 0)};
    go();
    `CHK("push addr", 16'h0008, a[0].addr)
    `CHK("push valid", 1'b1, a[0].valid)
    `CHK("sfr hit", 1'b1, a[8].sfr_hit)
    `CHK("ram no sfr", 1'b0, a[9].sfr_hit)
    `CHK("pop data", 8'h5A, a[2].rdata)
    `CHK("pop data", 8'hA5, a[3].rdata)
    `CHK("sp", 8'h07, a[4].rdata)
    `CHK("direct low", 8'hA5, a[5].rdata)
    `CHK("sfr apart", 8'h07, a[8].rdata)
    `CHK("upper ram", 8'h3C, a[9].rdata)
    for (int b = 0; b < 4; b++)
      `CHK("bank", 8'(8'h10 + b), a[13 + 4 * b].rdata)
    `CHK("bit set", 1'b1, a[28].bit_val)
    `CHK("bit clear", 1'b0, a[29].bit_val)
    `CHK("bit byte", 8'h80, a[31].rdata)
    `CHK("data_pointer_16bit addr", 16'h01FF, a[34].addr)
    `CHK("page", 8'h01, a[36].rdata)
    `CHK("xri addr", 16'h01FF, a[38].addr)
    `CHK("xri data", 8'hC3, a[38].rdata)
    flash_target <= 1;
    q = '{mk(DMAD_OP_XRI, 1, 0, 8'h99), mk(DMAD_OP_XRI, 0, 0, 0)};
    go();
    `CHK("flash wr", 2'b11, {a[0].flash_sel, a[0].flash_wr})
    `CHK("on_chip_external_ram kept", 8'hC3, a[1].rdata)
    for (int v = 0; v < 2; v++)
    begin
      large_variant <= v[0];
      r = mk(DMAD_OP_NONE, 0, 0, 0);
      r.code_rd = 1;
      r.code_addr = v ? DMAD_FLASH_END_LARGE : DMAD_FLASH_END_SMALL;
      q = '{r, r, r};
      q[0].code_addr = r.code_addr - 16'h0001;
      q[2].code_addr = r.code_addr + 16'h0001;
      go();
      `CHK("flash", 2'b10, {a[0].flash_sel, a[0].reserved})
      `CHK("lock", 1'b1, a[1].lock_byte)
      `CHK("reserved", 1'b1, a[2].reserved)
    end
    complete_run();
  end
endmodule
